// file: design/sbcec_erase_cmd.sv
`timescale 1ns/1ps
module sbcec_erase_cmd #(
	parameter int PWD_BYTES = 12
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// received bytes and mode
	input wire sbcec_pkg::sbcec_rx_t rxIn,
	input wire logic ioMode,
	// transmit bytes
	output logic txValid,
	output logic [7:0] txData,
	input wire logic txReady,
	// flash configuration
	input wire logic [7:0] eraseEnableCfg,
	input wire logic [8*PWD_BYTES-1:0] storedPwd,
	// flash erase control
	output logic eraseReq,
	input wire logic eraseDone,
	input wire logic eraseErr,
	// RAM transfer branch
	input wire sbcec_pkg::sbcec_ramfin_t ramFin,
	output logic jumpReq,
	output logic [31:0] jumpAddr
);
	sbcec_pkg::sbcec_state_t state_reg;
	sbcec_pkg::sbcec_state_t after_reg;
	logic txValid_reg;
	logic [7:0] txData_reg;
	logic eraseReq_reg;
	logic jumpReq_reg;
	logic [31:0] jumpAddr_reg;
	logic [3:0] prevNib_reg;
	logic [3:0] blkIdx_reg;
	logic [7:0] sum_reg;
	logic blkRxErr_reg;
	logic pwdErr_reg;
	logic [7:0] sumNext;
	logic rxErrSeen;
	logic pwdNeeded;
	logic byteMismatch;
	logic pwdUniform;

	assign txValid = txValid_reg;
	assign txData = txData_reg;
	assign eraseReq = eraseReq_reg;
	assign jumpReq = jumpReq_reg;
	assign jumpAddr = jumpAddr_reg;

	// io interface mode has no framing to check
	assign rxErrSeen = rxIn.err && !ioMode;
	assign pwdNeeded = (eraseEnableCfg != sbcec_pkg::ERASED_BYTE);
	assign sumNext = sum_reg + rxIn.data;

	sbcec_pwd_check #(
		.NBYTES(PWD_BYTES)
	) u_pwd (
		.storedPwd(storedPwd),
		.idx(blkIdx_reg),
		.rxByte(rxIn.data),
		.mismatch(byteMismatch),
		.uniform(pwdUniform)
	);

	////////////////////////////////////////////////////////////////////////////////
	// command sequencer and answer byte
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			state_reg <= sbcec_pkg::S_WAIT_CMD;
			after_reg <= sbcec_pkg::S_WAIT_CMD;
			txValid_reg <= 1'b0;
			txData_reg <= 8'h00;
			prevNib_reg <= sbcec_pkg::NIB_RESET;
		end
		else
		begin
			case (state_reg)
				sbcec_pkg::S_WAIT_CMD:
				begin
					if (rxIn.valid)
					begin
						txValid_reg <= 1'b1;
						state_reg <= sbcec_pkg::S_SEND;
						after_reg <= sbcec_pkg::S_WAIT_CMD;
						if (rxErrSeen)
							txData_reg <= {prevNib_reg, sbcec_pkg::ACK_RXERR};
						else if (rxIn.data == sbcec_pkg::CMD_ERASE)
						begin
							txData_reg <= rxIn.data;
							prevNib_reg <= rxIn.data[7:4];
							after_reg <= sbcec_pkg::S_RX_BLOCK;
						end
						else
							txData_reg <= {prevNib_reg, sbcec_pkg::ACK_BAD};
					end
				end
				sbcec_pkg::S_RX_BLOCK:
				begin
					// checksum byte closes the block; answer in fixed priority
					if (rxIn.valid && blkIdx_reg == sbcec_pkg::BLK_LAST)
					begin
						txValid_reg <= 1'b1;
						state_reg <= sbcec_pkg::S_SEND;
						after_reg <= sbcec_pkg::S_WAIT_CMD;
						if (blkRxErr_reg || rxErrSeen)
							txData_reg <= {prevNib_reg, sbcec_pkg::ACK_RXERR};
						else if (sumNext != sbcec_pkg::SUM_OK)
							txData_reg <= {prevNib_reg, sbcec_pkg::ACK_BAD};
						else if (pwdNeeded && (pwdErr_reg || pwdUniform))
							txData_reg <= {prevNib_reg, sbcec_pkg::ACK_BAD};
						else
						begin
							txData_reg <= {prevNib_reg, sbcec_pkg::ACK_GOOD};
							after_reg <= sbcec_pkg::S_RX_ENABLE;
						end
					end
				end
				sbcec_pkg::S_RX_ENABLE:
				begin
					if (rxIn.valid)
					begin
						txValid_reg <= 1'b1;
						state_reg <= sbcec_pkg::S_SEND;
						after_reg <= sbcec_pkg::S_WAIT_CMD;
						if (rxErrSeen)
							txData_reg <= {prevNib_reg, sbcec_pkg::ACK_RXERR};
						else if (rxIn.data == sbcec_pkg::CMD_ENABLE)
						begin
							txData_reg <= rxIn.data;
							after_reg <= sbcec_pkg::S_ERASE_REQ;
						end
						else
							txData_reg <= {prevNib_reg, sbcec_pkg::ACK_BAD};
					end
				end
				sbcec_pkg::S_SEND:
				begin
					if (txReady)
					begin
						txValid_reg <= 1'b0;
						state_reg <= after_reg;
					end
				end
				sbcec_pkg::S_ERASE_REQ:
				begin
					state_reg <= sbcec_pkg::S_ERASE_WAIT;
				end
				sbcec_pkg::S_ERASE_WAIT:
				begin
					if (eraseDone || eraseErr)
					begin
						txValid_reg <= 1'b1;
						txData_reg <= eraseErr ? sbcec_pkg::DONE_ERR : sbcec_pkg::DONE_OK;
						state_reg <= sbcec_pkg::S_SEND;
						after_reg <= sbcec_pkg::S_WAIT_CMD;
					end
				end
				default:
				begin
					state_reg <= sbcec_pkg::S_WAIT_CMD;
					txValid_reg <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// password and checksum block accumulation
	always_ff @(posedge core_clk)
	begin
		if (!nrst || state_reg != sbcec_pkg::S_RX_BLOCK)
		begin
			blkIdx_reg <= sbcec_pkg::BLK_FIRST;
			sum_reg <= sbcec_pkg::SUM_OK;
			blkRxErr_reg <= 1'b0;
			pwdErr_reg <= 1'b0;
		end
		else if (rxIn.valid)
		begin
			blkIdx_reg <= blkIdx_reg + 4'h1;
			sum_reg <= sumNext;
			// errors are sticky over the whole block, judged only at its end
			if (rxErrSeen)
				blkRxErr_reg <= 1'b1;
			if (pwdNeeded && blkIdx_reg != sbcec_pkg::BLK_LAST && byteMismatch)
				pwdErr_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// erase request pulse
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			eraseReq_reg <= 1'b0;
		else
			eraseReq_reg <= (state_reg == sbcec_pkg::S_SEND) && txReady
				&& (after_reg == sbcec_pkg::S_ERASE_REQ);
	end

	////////////////////////////////////////////////////////////////////////////////
	// branch after a good RAM transfer
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			jumpReq_reg <= 1'b0;
			jumpAddr_reg <= 32'h0000_0000;
		end
		else
		begin
			jumpReq_reg <= ramFin.valid && ramFin.ackOk;
			if (ramFin.valid && ramFin.ackOk)
				jumpAddr_reg <= ramFin.startAddr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	sequence seqEnableOk;
		state_reg == sbcec_pkg::S_RX_ENABLE && rxIn.valid && !rxErrSeen
			&& rxIn.data == sbcec_pkg::CMD_ENABLE;
	endsequence

	sequence seqAckLeaves;
		state_reg == sbcec_pkg::S_SEND && txReady;
	endsequence

	AST_JUMP: assert property (ramFin.valid && ramFin.ackOk
		|=> jumpReq && jumpAddr == $past(ramFin.startAddr))
		else $error("jump not taken to supplied address");
	AST_CMD_RXERR: assert property (state_reg == sbcec_pkg::S_WAIT_CMD
		&& rxIn.valid && rxErrSeen
		|=> txValid && txData == {$past(prevNib_reg), 4'h8}
		&& after_reg == sbcec_pkg::S_WAIT_CMD)
		else $error("command receive error answer wrong");
	AST_CMD_ECHO: assert property (state_reg == sbcec_pkg::S_WAIT_CMD
		&& rxIn.valid && !rxErrSeen && rxIn.data == 8'h40
		|=> txData == 8'h40 && after_reg == sbcec_pkg::S_RX_BLOCK)
		else $error("erase command not echoed");
	AST_CMD_BAD: assert property (state_reg == sbcec_pkg::S_WAIT_CMD
		&& rxIn.valid && !rxErrSeen && rxIn.data != 8'h40
		|=> txData[3:0] == 4'h1 && after_reg == sbcec_pkg::S_WAIT_CMD)
		else $error("undefined command answer wrong");
	// completion codes carry bit 3 by encoding, not as a receive error
	AST_IO_NOERR: assert property (ioMode && txValid && !$past(txValid)
		&& $past(state_reg) != sbcec_pkg::S_ERASE_WAIT |-> txData[3] == 1'b0)
		else $error("receive error reported in io mode");
	AST_BLK_GOOD: assert property (txValid && txData == 8'h40
		&& $past(state_reg) == sbcec_pkg::S_RX_BLOCK |-> after_reg == sbcec_pkg::S_RX_ENABLE)
		else $error("good block ack did not advance");
	AST_BLK_RXERR: assert property (state_reg == sbcec_pkg::S_RX_BLOCK
		&& rxIn.valid && blkIdx_reg == 4'hC && (blkRxErr_reg || rxErrSeen)
		|=> txData == 8'h48)
		else $error("block receive error not answered 0x48");
	AST_BLK_SUM: assert property (state_reg == sbcec_pkg::S_RX_BLOCK
		&& rxIn.valid && blkIdx_reg == 4'hC && !blkRxErr_reg && !rxErrSeen
		&& sumNext != 8'h00 |=> txData == 8'h41)
		else $error("bad checksum not answered 0x41");
	AST_ENABLE_ECHO: assert property (seqEnableOk
		|=> txValid && txData == 8'h54 && after_reg == sbcec_pkg::S_ERASE_REQ)
		else $error("enable byte not echoed");
	AST_ENABLE_ERASE: assert property (seqAckLeaves
		##0 (after_reg == sbcec_pkg::S_ERASE_REQ) |=> eraseReq ##1 !eraseReq)
		else $error("enable echo did not start one erase");
	AST_DONE_CODE: assert property (state_reg == sbcec_pkg::S_ERASE_WAIT
		&& (eraseDone || eraseErr)
		|=> txValid && txData == ($past(eraseErr) ? 8'h4C : 8'h4F)
		&& after_reg == sbcec_pkg::S_WAIT_CMD)
		else $error("completion code wrong");
	AST_HOLD_DONE: assert property (state_reg == sbcec_pkg::S_ERASE_WAIT
		&& !eraseDone && !eraseErr |=> !txValid)
		else $error("completion sent before flash finished");
endmodule : sbcec_erase_cmd

// file: design/sbcec_pkg.sv
// Function
// - after a good final RAM transfer acknowledge, jump to the supplied start address.
// - receive error on command byte answers prior nibble with bit 3, rewaits.
// - valid erase command byte is echoed back as the fourth byte.
// - undefined command answers prior nibble with bit 0, then waits for command.
// - enable byte not 0xFF makes bytes 5..16 a password compared in order.
// - enable byte 0xFF needs no password; bytes 5..16 are dummy data.
// - receive error in bytes 5..17 answers 0x48 and returns to command wait.
// - clocked I/O interface mode skips all receive error checks.
// - block sum modulo 256 not zero answers 0x41 and returns to wait.
// - uniform non-0xFF stored password or any mismatch answers 0x41, rewaits.
// - all block checks passing answers normal acknowledge 0x40 as byte 18.
// - good enable byte echoes 0x54 and erases; receive error answers bit 3.
// - invalid enable code answers prior nibble with bit 0, then waits.
// - after erase send 0x4F on success or 0x4C on error.
// - byte after completion code is taken as a new command.
// - ack upper nibble is command nibble; bit 3 rx error; bit 0 error.
package sbcec_pkg;
	localparam logic [7:0] CMD_ERASE = 8'h40;
	localparam logic [7:0] CMD_ENABLE = 8'h54;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] SUM_OK = 8'h00;
	localparam logic [7:0] DONE_OK = 8'h4F;
	localparam logic [7:0] DONE_ERR = 8'h4C;
	localparam logic [3:0] ACK_RXERR = 4'h8;
	localparam logic [3:0] ACK_BAD = 4'h1;
	localparam logic [3:0] ACK_GOOD = 4'h0;
	localparam logic [3:0] NIB_RESET = 4'h0;
	localparam int PWD_BYTES = 12;
	localparam logic [3:0] BLK_LAST = 4'hC;
	localparam logic [3:0] BLK_FIRST = 4'h0;

	typedef struct packed {
		logic valid;
		logic err;
		logic [7:0] data;
	} sbcec_rx_t;

	typedef struct packed {
		logic valid;
		logic ackOk;
		logic [31:0] startAddr;
	} sbcec_ramfin_t;

	typedef enum logic [2:0] {
		S_WAIT_CMD,
		S_RX_BLOCK,
		S_RX_ENABLE,
		S_SEND,
		S_ERASE_REQ,
		S_ERASE_WAIT
	} sbcec_state_t;
endpackage : sbcec_pkg

// file: design/sbcec_pwd_check.sv
`timescale 1ns/1ps
module sbcec_pwd_check #(
	parameter int NBYTES = 12
) (
	// stored password area, byte 0 in the low bits
	input wire logic [8*NBYTES-1:0] storedPwd,
	// byte under test
	input wire logic [3:0] idx,
	input wire logic [7:0] rxByte,
	// results
	output logic mismatch,
	output logic uniform
);
	logic [NBYTES-1:0] sameAsFirst;
	logic [7:0] selByte;

	genvar gi;
	generate
		for (gi = 0; gi < NBYTES; gi++)
		begin : g_same
			assign sameAsFirst[gi] = (storedPwd[8*gi +: 8] == storedPwd[7:0]);
		end
	endgenerate

	always_comb
	begin
		selByte = 8'h00;
		for (int i = 0; i < NBYTES; i++)
		begin
			if (idx == i[3:0])
				selByte = storedPwd[8*i +: 8];
		end
	end

	assign mismatch = (selByte != rxByte);
	// easy-to-guess fill is refused even when it matches
	assign uniform = (&sameAsFirst) && (storedPwd[7:0] != sbcec_pkg::ERASED_BYTE);
endmodule : sbcec_pwd_check

// file: sim/sbcec_flash_model.sv
`timescale 1ns/1ps
module sbcec_flash_model #(
	parameter int DELAY = 5
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// erase handshake
	input wire logic eraseReq,
	input wire logic failNext,
	output logic eraseDone,
	output logic eraseErr
);
	int count_reg;
	// completion held off several cycles so an early completion byte shows up
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			count_reg <= 0;
		else if (eraseReq)
			count_reg <= DELAY;
		else if (count_reg > 0)
			count_reg <= count_reg - 1;
	end
	assign eraseDone = (count_reg == 1) && !failNext;
	assign eraseErr = (count_reg == 1) && failNext;
endmodule : sbcec_flash_model

// file: sim/tb_sbcec_erase_cmd.sv
`timescale 1ns/1ps
module tb_sbcec_erase_cmd;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	sbcec_pkg::sbcec_rx_t rxIn = '0;
	logic ioMode = 1'b0;
	logic txValid;
	logic [7:0] txData;
	logic txReady = 1'b0;
	logic [7:0] eraseEnableCfg = 8'hFF;
	logic [95:0] storedPwd = '0;
	logic eraseReq;
	logic eraseDone;
	logic eraseErr;
	logic failNext = 1'b0;
	sbcec_pkg::sbcec_ramfin_t ramFin = '0;
	logic jumpReq;
	logic [31:0] jumpAddr;
	logic [95:0] goodPwd;
	int num_errors = 0;
	int total_checks = 0;
	int reqCount = 0;
	////////////////////////////////////////////////////////////////////////////
	sbcec_erase_cmd #(.PWD_BYTES(12)) uut (.core_clk(core_clk), .nrst(nrst), .rxIn(rxIn),
		.ioMode(ioMode), .txValid(txValid), .txData(txData), .txReady(txReady),
		.eraseEnableCfg(eraseEnableCfg), .storedPwd(storedPwd), .eraseReq(eraseReq),
		.eraseDone(eraseDone), .eraseErr(eraseErr), .ramFin(ramFin), .jumpReq(jumpReq),
		.jumpAddr(jumpAddr));
	sbcec_flash_model #(.DELAY(5)) flash (.core_clk(core_clk), .nrst(nrst),
		.eraseReq(eraseReq), .failNext(failNext), .eraseDone(eraseDone), .eraseErr(eraseErr));
	initial
	begin
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		if (eraseReq === 1'b1)
			reqCount <= reqCount + 1;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic send(input logic [7:0] d, input logic e);
		@(negedge core_clk);
		rxIn = {1'b1, e, d};
		@(negedge core_clk);
		rxIn = '0;
	endtask : send
	// bounded wait, then take the byte with a one-cycle ready
	task automatic expectTx(input logic [7:0] exp);
		int n;
		n = 0;
		while (txValid !== 1'b1 && n < 60)
		begin
			@(negedge core_clk);
			n++;
		end
		if (txValid !== 1'b1)
		begin
			num_errors++;
			report_and_stop();
		end
		chk(txData, exp);
		txReady = 1'b1;
		@(negedge core_clk);
		txReady = 1'b0;
		chk(txValid, 1'b0);
	endtask : expectTx
	// checksum from the twelve bytes; adj spoils it, errAt flags one byte
	task automatic session(input logic [95:0] pw, input logic [7:0] adj, input int errAt,
		input logic [7:0] ack);
		logic [7:0] s;
		s = 8'h00;
		send(sbcec_pkg::CMD_ERASE, 1'b0);
		expectTx(8'h40);
		for (int i = 0; i < 12; i++)
		begin
			send(pw[8*i+:8], i == errAt);
			s = s + pw[8*i+:8];
		end
		chk(txValid, 1'b0);
		send(8'h00 - s + adj, errAt == 12);
		expectTx(ack);
	endtask : session
	////////////////////////////////////////////////////////////////////////////
	task automatic t_command();
		send(8'h10, 1'b0);
		expectTx(8'h01);
		send(8'h40, 1'b1);
		expectTx(8'h08);
	endtask : t_command
	task automatic t_erase(input logic fail);
		failNext = fail;
		reqCount = 0;
		session(96'h1234_5678_9ABC_DEF0_1122_3344, 8'h00, 99, 8'h40);
		send(sbcec_pkg::CMD_ENABLE, 1'b0);
		expectTx(8'h54);
		expectTx(fail ? 8'h4C : 8'h4F);
		chk(reqCount, 1);
		send(8'h33, 1'b0);
		expectTx(8'h41);
	endtask : t_erase
	task automatic t_block_faults();
		session(goodPwd, 8'h01, 99, 8'h41);
		session(goodPwd, 8'h00, 12, 8'h48);
		session(goodPwd, 8'h00, 3, 8'h48);
		// bench stands in for the mode detector after a 0x30 first byte
		ioMode = 1'b1;
		session(goodPwd, 8'h00, 3, 8'h40);
		ioMode = 1'b0;
		send(8'h55, 1'b0);
		expectTx(8'h41);
		session(goodPwd, 8'h00, 99, 8'h40);
		send(sbcec_pkg::CMD_ENABLE, 1'b1);
		expectTx(8'h48);
	endtask : t_block_faults
	task automatic t_password();
		eraseEnableCfg = 8'h00;
		storedPwd = goodPwd;
		session(goodPwd, 8'h00, 99, 8'h40);
		send(8'h55, 1'b0);
		expectTx(8'h41);
		session(goodPwd ^ 96'h0000_0000_0000_0000_0000_0100, 8'h00, 99, 8'h41);
		storedPwd = {12{8'h5A}};
		session({12{8'h5A}}, 8'h00, 99, 8'h41);
		eraseEnableCfg = 8'hFF;
	endtask : t_password
	task automatic t_jump();
		@(negedge core_clk);
		ramFin = {1'b1, 1'b1, 32'h2000_0100};
		@(negedge core_clk);
		ramFin = {1'b1, 1'b0, 32'h3000_0200};
		chk(jumpReq, 1'b1);
		chk(jumpAddr, 32'h2000_0100);
		@(negedge core_clk);
		ramFin = '0;
		chk(jumpReq, 1'b0);
		chk(jumpAddr, 32'h2000_0100);
	endtask : t_jump
	// reset with a reply pending drops it and forgets the command nibble
	task automatic t_reset();
		send(sbcec_pkg::CMD_ERASE, 1'b0);
		chk(txValid, 1'b1);
		nrst = 1'b0;
		@(negedge core_clk);
		chk(txValid, 1'b0);
		chk(txData, 8'h00);
		nrst = 1'b1;
		send(8'h10, 1'b0);
		expectTx(8'h01);
	endtask : t_reset
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		for (int i = 0; i < 12; i++)
			goodPwd[8*i+:8] = 8'h01 + i;
		repeat (6) @(negedge core_clk);
		nrst = 1'b1;
		chk(txValid, 1'b0);
		chk(eraseReq, 1'b0);
		chk(jumpReq, 1'b0);
		chk(jumpAddr, 32'h0000_0000);
		t_command();
		t_erase(1'b0);
		t_erase(1'b1);
		t_block_faults();
		t_password();
		t_jump();
		t_reset();
		report_and_stop();
	end
endmodule : tb_sbcec_erase_cmd
